// File: hw/rmlc_crc_engine.sv
// One-word-per-cycle CRC-16 engine over 24-bit map words
`timescale 1ns/1ps
`include "rmlc_params.svh"
module rmlc_crc_engine
   import rmlc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   rmlc_crc_if.engine_side crc_bus
);
   // ==========================================================
   // Arithmetic
   function automatic rmlc_crc_type crc_step(input rmlc_crc_type seed, input rmlc_word_type w);
      rmlc_crc_type c;
      c = seed;
      for (int i = 23; i >= 0; i--) begin
         if (c[15] ^ w[i]) begin
            c = {c[14:0], 1'b0} ^ `RMLC_CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction

   // ==========================================================
   // State
   rmlc_crc_state_type st_reg;
   rmlc_crc_state_type st_next;
   rmlc_crc_type base;

   always_comb begin
      st_next = st_reg;
      base = crc_bus.clear ? `RMLC_CRC_SEED : st_reg.crc;
      if (crc_bus.feed) begin
         st_next.crc = crc_step(base, crc_bus.word);
      end else begin
         st_next.crc = base;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign crc_bus.crc = st_reg.crc;

   chk_crc_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      crc_bus.clear && !crc_bus.feed |=> st_reg.crc == `RMLC_CRC_SEED)
      else $error("checksum engine did not return to seed");
endmodule // rmlc_crc_engine

// File: hw/rmlc_crc_if.sv
// Carrier between the lock logic and the checksum engine
`timescale 1ns/1ps
interface rmlc_crc_if;
   import rmlc_pkg::*;
   logic clear;
   logic feed;
   rmlc_word_type word;
   rmlc_crc_type crc;
   modport lock_side (output clear, output feed, output word, input crc);
   modport engine_side (input clear, input feed, input word, output crc);
endinterface

// File: hw/rmlc_lock_top.sv
// Register map write lock with periodic checksum and alert
`timescale 1ns/1ps
`include "rmlc_params.svh"
module rmlc_lock_top
   import rmlc_pkg::*;
#(
   parameter int N_WORDS = 8
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [`RMLC_ADDR_W-1:0] addr_in,
   input wire logic [`RMLC_WORD_W-1:0] wdata_in,
   input wire logic alert_en_in,
   output logic [`RMLC_WORD_W-1:0] rdata_out,
   output logic rvalid_out,
   output logic wr_ignored_out,
   output logic locked_out,
   output logic [15:0] config_checksum_out,
   output logic crc_alert_out
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [N_WORDS-1:0][`RMLC_WORD_W-1:0] map;
      logic [7:0] key;
      logic locked;
      rmlc_crc_type checksum;
      rmlc_crc_type ref_sum;
      logic ref_ok;
      logic alert;
      logic [3:0] count;
      rmlc_word_type rdata;
      logic rvalid;
      logic wr_ignored;
   } rmlc_state_type;

   rmlc_state_type st_reg;
   rmlc_state_type st_next;
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   logic wr_key;
   logic [`RMLC_ADDR_W-1:0] wr_idx;
   rmlc_crc_if crc_bus ();

   // ==========================================================
   // Reset release
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_pipe_reg <= 2'b00;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_reg[1];

   // ==========================================================
   // Address decode
   function automatic logic map_hit(input logic [`RMLC_ADDR_W-1:0] a);
      logic [`RMLC_ADDR_W:0] top;
      top = {1'b0, `RMLC_MAP_BASE} + (`RMLC_ADDR_W+1)'(N_WORDS);
      return (a >= `RMLC_MAP_BASE) && ({1'b0, a} < top) && (a != `RMLC_KEY_ADDR);
   endfunction

   function automatic logic [`RMLC_ADDR_W-1:0] map_idx(input logic [`RMLC_ADDR_W-1:0] a);
      return a - `RMLC_MAP_BASE;
   endfunction

   assign wr_key = wr_en_in && (addr_in == `RMLC_KEY_ADDR);
   assign wr_idx = map_idx(addr_in);

   // ==========================================================
   // Checksum engine
   rmlc_crc_engine u_crc (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n),
      .crc_bus(crc_bus)
   );

   // Walk the map one word per cycle; N_WORDS must stay below the refresh period
   always_comb begin
      crc_bus.clear = (st_reg.count == 4'h0);
      crc_bus.feed = st_reg.locked && (32'(st_reg.count) < N_WORDS);
      crc_bus.word = '0;
      if (crc_bus.feed) begin
         crc_bus.word = st_reg.map[st_reg.count];
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      st_next.wr_ignored = 1'b0;
      if (wr_key) begin
         st_next.key = wdata_in[`RMLC_KEY_MSB:`RMLC_KEY_LSB];
      end else if (wr_en_in && !st_reg.locked && map_hit(addr_in)) begin
         st_next.map[wr_idx] = wdata_in;
      end else if (wr_en_in) begin
         st_next.wr_ignored = 1'b1;
      end
      st_next.locked = (st_next.key != `RMLC_PASSWORD);
      if (!st_next.locked) begin
         st_next.checksum = `RMLC_CSUM_RESET;
         st_next.alert = 1'b0;
         st_next.ref_ok = 1'b0;
         st_next.count = 4'h0;
      end else if (st_reg.locked) begin
         if (st_reg.count == `RMLC_REFRESH_LAST) begin
            st_next.count = 4'h0;
            st_next.checksum = crc_bus.crc;
            if (!st_reg.ref_ok) begin
               st_next.ref_sum = crc_bus.crc;
               st_next.ref_ok = 1'b1;
            end else if (alert_en_in && (crc_bus.crc != st_reg.ref_sum)) begin
               st_next.alert = 1'b1;
            end
         end else begin
            st_next.count = st_reg.count + 4'h1;
         end
      end
      if (rd_en_in) begin
         st_next.rvalid = 1'b1;
         if (addr_in == `RMLC_KEY_ADDR) begin
            st_next.rdata = {st_reg.key, st_reg.checksum};
         end else if (st_reg.locked || !map_hit(addr_in)) begin
            st_next.rdata = `RMLC_UNDEF_READ;
         end else begin
            st_next.rdata = st_reg.map[map_idx(addr_in)];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.key <= `RMLC_KEY_RESET;
         st_reg.checksum <= `RMLC_CSUM_RESET;
         st_reg.map <= {N_WORDS{`RMLC_MAP_RESET}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata_out = st_reg.rdata;
   assign rvalid_out = st_reg.rvalid;
   assign wr_ignored_out = st_reg.wr_ignored;
   assign locked_out = st_reg.locked;
   assign config_checksum_out = st_reg.checksum;
   assign crc_alert_out = st_reg.alert;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n);

   chk_unlocked_write: assert property (wr_en_in && !wr_key && !st_reg.locked
      && map_hit(addr_in) |=> st_reg.map[$past(wr_idx)] == $past(wdata_in) && !wr_ignored_out)
      else $error("unlocked map write not stored");
   chk_unlock_clears: assert property (!st_reg.locked
      |-> config_checksum_out == 16'h0000 && !crc_alert_out)
      else $error("checksum or alert not cleared while unlocked");
   chk_no_crc_open: assert property (!st_reg.locked |-> !crc_bus.feed)
      else $error("checksum running while unlocked");
   chk_locked_ignore: assert property (st_reg.locked && wr_en_in && !wr_key
      |=> $stable(st_reg.map) && wr_ignored_out)
      else $error("locked write reached the map");
   chk_locked_read: assert property (st_reg.locked && rd_en_in
      && addr_in != `RMLC_KEY_ADDR |=> rvalid_out && rdata_out == `RMLC_UNDEF_READ)
      else $error("locked read leaked map contents");
   chk_alert_gate: assert property ($rose(crc_alert_out)
      |-> $past(alert_en_in) && $past(st_reg.locked))
      else $error("alert raised without enable");
   chk_csum_readonly: assert property (st_reg.locked && st_next.locked
      && st_reg.count != `RMLC_REFRESH_LAST |=> $stable(config_checksum_out))
      else $error("checksum changed outside refresh");
   chk_refresh_period: assert property (st_reg.locked && st_reg.count == 4'h0
      && st_next.locked ##1 st_next.locked [*8] |=> st_reg.count == `RMLC_REFRESH_LAST)
      else $error("refresh period not ten cycles");
   chk_key_read: assert property (rd_en_in && addr_in == `RMLC_KEY_ADDR
      |=> rdata_out == {$past(st_reg.key), $past(st_reg.checksum)})
      else $error("key register read wrong");
   chk_crc_feed: assert property (crc_bus.feed
      |-> crc_bus.word == st_reg.map[st_reg.count])
      else $error("checksum fed wrong word");

   // ==========================================================
   // Checks on key writes, refresh counter, alert, read pulses, unmapped writes and unlocked reads
   chk_key_relock: assert property (wr_key
      && wdata_in[`RMLC_KEY_MSB:`RMLC_KEY_LSB] != `RMLC_PASSWORD
      |=> locked_out && !wr_ignored_out)
      else $error("key write did not lock the map");
   chk_key_unlock: assert property (wr_key
      && wdata_in[`RMLC_KEY_MSB:`RMLC_KEY_LSB] == `RMLC_PASSWORD
      |=> !locked_out && config_checksum_out == 16'h0000 && !crc_alert_out)
      else $error("password write did not open the map");
   chk_lock_state: assert property (st_reg.locked == (st_reg.key != `RMLC_PASSWORD))
      else $error("lock flag disagrees with key");
   chk_refresh_update: assert property (st_reg.locked && st_next.locked
      && st_reg.count == `RMLC_REFRESH_LAST |=> config_checksum_out == $past(crc_bus.crc))
      else $error("checksum not taken at refresh");
   chk_count_range: assert property (st_reg.count <= `RMLC_REFRESH_LAST)
      else $error("refresh counter out of range");
   chk_count_idle: assert property (!st_reg.locked |-> st_reg.count == 4'h0)
      else $error("refresh counter running while unlocked");
   // The alert fires only if map storage changes under lock, e.g. from an upset;
   // host map writes are refused then, so ordinary stimulus never raises it.
   chk_alert_sticky: assert property (crc_alert_out && st_next.locked
      |=> crc_alert_out)
      else $error("alert dropped while locked");
   chk_alert_enable: assert property (!alert_en_in && !crc_alert_out
      |=> !crc_alert_out)
      else $error("alert rose with enable low");
   chk_read_pulse: assert property (!rd_en_in |=> !rvalid_out)
      else $error("read answer without a read");
   chk_unmapped_ignore: assert property (wr_en_in && !wr_key && !map_hit(addr_in)
      |=> wr_ignored_out && $stable(st_reg.map))
      else $error("unmapped write not refused");
   chk_unlocked_read: assert property (rd_en_in && !wr_en_in && !st_reg.locked
      && map_hit(addr_in) |=> rvalid_out && rdata_out == st_reg.map[$past(wr_idx)])
      else $error("unlocked read returned wrong word");
endmodule // rmlc_lock_top

// File: hw/rmlc_params.svh
// Constants of the register map lock and checksum block
`ifndef RMLC_PARAMS_SVH
`define RMLC_PARAMS_SVH
`define RMLC_ADDR_W 5
`define RMLC_WORD_W 24
`define RMLC_KEY_ADDR 5'h1F
`define RMLC_MAP_BASE 5'h00
`define RMLC_KEY_MSB 23
`define RMLC_KEY_LSB 16
`define RMLC_CSUM_MSB 15
`define RMLC_CSUM_LSB 0
`define RMLC_PASSWORD 8'hA5
`define RMLC_KEY_RESET 8'hA5
`define RMLC_CSUM_RESET 16'h0000
`define RMLC_MAP_RESET 24'h000000
`define RMLC_UNDEF_READ 24'h000000
`define RMLC_CRC_POLY 16'h8005
`define RMLC_CRC_SEED 16'h0000
`define RMLC_REFRESH_PERIODS 10
`define RMLC_REFRESH_LAST 4'h9
`endif

// File: hw/rmlc_pkg.sv
// Types shared by the register map lock and checksum block
package rmlc_pkg;
   typedef logic [23:0] rmlc_word_type;
   typedef logic [15:0] rmlc_crc_type;
   typedef struct packed {
      rmlc_crc_type crc;
   } rmlc_crc_state_type;
endpackage

// File: sim/rmlc_host_model.sv
// Host-side access model for the register map lock block
`timescale 1ns/1ps
module rmlc_host_model (
   input wire logic mclk_in,
   input wire logic rvalid_in,
   input wire logic ignored_in,
   input wire logic [23:0] rdata_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [4:0] addr_out,
   output logic [23:0] wdata_out
);
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 5'h00;
      wdata_out = 24'h000000;
   end
   // Idle lines show the inverse so a stale value never looks valid
   task automatic idle();
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
   endtask
   task automatic wr(input logic [4:0] a, input logic [23:0] d, output logic ign);
      @(posedge mclk_in);
      #1;
      wr_en_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(posedge mclk_in);
      #1;
      ign = ignored_in;
      idle();
   endtask
   task automatic rd(input logic [4:0] a, output logic [23:0] d);
      int n;
      @(posedge mclk_in);
      #1;
      rd_en_out = 1'b1;
      addr_out = a;
      @(posedge mclk_in);
      #1;
      idle();
      n = 0;
      while (rvalid_in !== 1'b1 && n < 4) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      d = (rvalid_in === 1'b1) ? rdata_in : 24'hXXXXXX;
   endtask
endmodule // rmlc_host_model

// File: sim/testbench.sv
// Self-checking bench for the register map lock and checksum block
`timescale 1ns/1ps
`include "rmlc_params.svh"
module testbench;
   import rmlc_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, alert_en = 1'b0, wr_en, rd_en, rvalid, ign, locked, alert;
   logic [4:0] addr;
   logic [23:0] wdata, rdata, d;
   logic [15:0] csum, exp_crc;
   logic [23:0] w [8];
   int n_errors = 0, num_checks = 0;
   always #12.5 mclk = ~mclk;
   rmlc_lock_top #(.N_WORDS(8)) u_dut (.mclk_in(mclk), .resetn_in(resetn), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .alert_en_in(alert_en),
      .rdata_out(rdata), .rvalid_out(rvalid), .wr_ignored_out(ign), .locked_out(locked),
      .config_checksum_out(csum), .crc_alert_out(alert));
   rmlc_host_model u_host (.mclk_in(mclk), .rvalid_in(rvalid), .ignored_in(ign),
      .rdata_in(rdata), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
      .wdata_out(wdata));
   // ===========
   // Checking
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Bit-serial reference, MSB first over ascending words
   function automatic logic [15:0] crc_of();
      logic [15:0] c;
      logic fb;
      c = `RMLC_CRC_SEED;
      for (int i = 0; i < 8; i++) begin
         for (int b = 23; b >= 0; b--) begin
            fb = c[15] ^ w[i][b];
            c = {c[14:0], 1'b0};
            if (fb) c = c ^ `RMLC_CRC_POLY;
         end
      end
      return c;
   endfunction
   // ===========
   // Tests
   initial begin
      logic g;
      repeat (8) @(posedge mclk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      u_host.rd(5'h1F, d);
      check("key after reset", d, {`RMLC_PASSWORD, 16'h0000});
      check("locked after reset", 24'(locked), 24'h000000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         w[i] = 24'(24'h111111 * (i + 1));
         u_host.wr(5'(i), w[i], g);
         check("unlocked write refused", 24'(g), 24'h000000);
      end
      for (int i = 0; i < 8; i++) begin
         u_host.rd(5'(i), d);
         check("map word", d, w[i]);
      end
      u_host.wr(5'h08, 24'h123456, g);
      check("unmapped write", 24'(g), 24'h000001);
      repeat (30) @(posedge mclk);
      #1;
      check("checksum unlocked", 24'(csum), 24'h000000);
      check("alert unlocked", 24'(alert), 24'h000000);
      $display("test unlocked done");
      exp_crc = crc_of();
      alert_en = 1'b1;
      u_host.wr(5'h1F, 24'h3C0000, g);
      check("lock write", 24'(g), 24'h000000);
      check("locked", 24'(locked), 24'h000001);
      repeat (8) @(posedge mclk);
      #1;
      check("checksum early", 24'(csum), 24'h000000);
      repeat (3) @(posedge mclk);
      #1;
      check("checksum", 24'(csum), 24'(exp_crc));
      u_host.wr(5'h02, 24'hABCDEF, g);
      check("locked write", 24'(g), 24'h000001);
      u_host.rd(5'h03, d);
      check("locked read", d, `RMLC_UNDEF_READ);
      u_host.wr(5'h1F, 24'h3CFFFF, g);
      repeat (12) @(posedge mclk);
      #1;
      u_host.rd(5'h1F, d);
      check("key register", d, {8'h3C, exp_crc});
      check("alert frozen map", 24'(alert), 24'h000000);
      alert_en = 1'b0;
      $display("test locked done");
      u_host.wr(5'h1F, {`RMLC_PASSWORD, 16'h0000}, g);
      check("unlocked", 24'(locked), 24'h000000);
      check("checksum cleared", 24'(csum), 24'h000000);
      check("alert cleared", 24'(alert), 24'h000000);
      u_host.rd(5'h02, d);
      check("word kept", d, w[2]);
      u_host.wr(5'h02, 24'hABCDEF, g);
      u_host.rd(5'h02, d);
      check("word after unlock", d, 24'hABCDEF);
      $display("test unlock done");
      conclude();
   end
   initial begin
      repeat (3000) @(posedge mclk);
      n_errors++;
      $display("watchdog expired");
      conclude();
   end
endmodule // testbench
